// [rtl/rtcti_pkg.sv]
package rtcti_pkg;
  // special function register addresses
  localparam logic [7:0] RTCTI_ADDR_CTRL = 8'ha1;
  localparam logic [7:0] RTCTI_ADDR_SUBSEC = 8'ha2;
  localparam logic [7:0] RTCTI_ADDR_SEC = 8'ha3;
  localparam logic [7:0] RTCTI_ADDR_MIN = 8'ha4;
  localparam logic [7:0] RTCTI_ADDR_HOUR = 8'ha5;
  localparam logic [7:0] RTCTI_ADDR_IVAL = 8'ha6;
  // reset values
  localparam logic [7:0] RTCTI_RST_COUNT = 8'h00;
  localparam logic [7:0] RTCTI_RST_CTRL = 8'h00;
  // counter limits
  localparam logic [7:0] RTCTI_SUBSEC_MAX = 8'h7f;
  localparam logic [7:0] RTCTI_SEC_MAX = 8'h3b;
  localparam logic [7:0] RTCTI_MIN_MAX = 8'h3b;
  localparam logic [7:0] RTCTI_HOUR24_MAX = 8'h17;
  localparam logic [7:0] RTCTI_HOUR_FULL_MAX = 8'hff;
  // control register field positions
  localparam int RTCTI_BIT_CLK_EN = 0;
  localparam int RTCTI_BIT_IVAL_EN = 1;
  localparam int RTCTI_BIT_FLAG = 2;
  localparam int RTCTI_BIT_SINGLE = 3;
  localparam int RTCTI_BIT_TB_LO = 4;
  localparam int RTCTI_BIT_TB_HI = 5;
  localparam int RTCTI_BIT_24H = 6;

  typedef enum logic [1:0] {
    RTCTI_TB_SUBSEC = 2'b00,
    RTCTI_TB_SEC = 2'b01,
    RTCTI_TB_MIN = 2'b10,
    RTCTI_TB_HOUR = 2'b11
  } rtcti_timebase_e;

  typedef struct packed {
    logic unused;
    logic day_hour_mode;
    rtcti_timebase_e timebase;
    logic single_interval_mode;
    logic interval_match_flag;
    logic interval_counter_enable;
    logic time_clock_enable;
  } rtcti_ctrl_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcti_sfr_s;
endpackage : rtcti_pkg

// [rtl/rtcti_top.sv]
`timescale 1ns/1ps
`default_nettype none
module rtcti_top
  import rtcti_pkg::*;
#(
  parameter int unsigned CNT_W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic tick_128,
  input wire rtcti_pkg::rtcti_sfr_s sfr,
  output logic [7:0] sfr_rdata,
  output logic interval_match_flag
);
  import rtcti_pkg::*;

  function automatic logic [7:0] rtcti_wrap_inc(input logic [7:0] v, input logic [7:0] max);
    rtcti_wrap_inc = (v == max) ? 8'h00 : 8'(v + 8'h01);
  endfunction : rtcti_wrap_inc

  rtcti_ctrl_s ctrl_q;
  logic [7:0] subsecond_count_q;
  logic [7:0] rtc_s_count_q;
  logic [7:0] rtc_m_count_q;
  logic [7:0] rtc_h_count_q;
  logic [CNT_W-1:0] interval_compare_reg_q;
  logic [CNT_W-1:0] time_interval_counter_q;
  logic [CNT_W-1:0] ival_next;
  logic [7:0] sfr_rdata_q;
  logic wr_ctrl, wr_sub, wr_sec, wr_min, wr_hour, wr_ival;
  logic sub_tick, sec_tick, min_tick, hour_tick, tb_tick, timeout;
  logic [7:0] hour_max;
  rtcti_ctrl_s wctrl;

  assign wctrl = rtcti_ctrl_s'(sfr.wdata);

  always_comb begin
    wr_ctrl = 1'b0;
    wr_sub = 1'b0;
    wr_sec = 1'b0;
    wr_min = 1'b0;
    wr_hour = 1'b0;
    wr_ival = 1'b0;
    if (sfr.addr == RTCTI_ADDR_CTRL) begin
      wr_ctrl = sfr.wr;
    end else if (sfr.addr == RTCTI_ADDR_SUBSEC) begin
      wr_sub = sfr.wr;
    end else if (sfr.addr == RTCTI_ADDR_SEC) begin
      wr_sec = sfr.wr;
    end else if (sfr.addr == RTCTI_ADDR_MIN) begin
      wr_min = sfr.wr;
    end else if (sfr.addr == RTCTI_ADDR_HOUR) begin
      wr_hour = sfr.wr;
    end else if (sfr.addr == RTCTI_ADDR_IVAL) begin
      wr_ival = sfr.wr;
    end
  end

  // tick chain, gated by the clock enable
  assign sub_tick = ctrl_q.time_clock_enable & tick_128;
  assign sec_tick = sub_tick & (subsecond_count_q == RTCTI_SUBSEC_MAX);
  assign min_tick = sec_tick & (rtc_s_count_q == RTCTI_SEC_MAX);
  assign hour_tick = min_tick & (rtc_m_count_q == RTCTI_MIN_MAX);
  assign hour_max = ctrl_q.day_hour_mode ? RTCTI_HOUR24_MAX : RTCTI_HOUR_FULL_MAX;

  always_comb begin
    case (ctrl_q.timebase)
      RTCTI_TB_SUBSEC: tb_tick = sub_tick;
      RTCTI_TB_SEC: tb_tick = sec_tick;
      RTCTI_TB_MIN: tb_tick = min_tick;
      default: tb_tick = hour_tick;
    endcase
  end

  assign ival_next = CNT_W'(time_interval_counter_q + 1'b1);
  assign timeout = ctrl_q.interval_counter_enable & tb_tick
                   & (ival_next == interval_compare_reg_q);

  // time counters: software write wins over counting
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      subsecond_count_q <= RTCTI_RST_COUNT;
    end else if (wr_sub) begin
      subsecond_count_q <= sfr.wdata;
    end else if (sub_tick) begin
      subsecond_count_q <= rtcti_wrap_inc(subsecond_count_q, RTCTI_SUBSEC_MAX);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rtc_s_count_q <= RTCTI_RST_COUNT;
    end else if (wr_sec) begin
      rtc_s_count_q <= sfr.wdata;
    end else if (sec_tick) begin
      rtc_s_count_q <= rtcti_wrap_inc(rtc_s_count_q, RTCTI_SEC_MAX);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rtc_m_count_q <= RTCTI_RST_COUNT;
    end else if (wr_min) begin
      rtc_m_count_q <= sfr.wdata;
    end else if (min_tick) begin
      rtc_m_count_q <= rtcti_wrap_inc(rtc_m_count_q, RTCTI_MIN_MAX);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rtc_h_count_q <= RTCTI_RST_COUNT;
    end else if (wr_hour) begin
      rtc_h_count_q <= sfr.wdata;
    end else if (hour_tick) begin
      rtc_h_count_q <= rtcti_wrap_inc(rtc_h_count_q, hour_max);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interval_compare_reg_q <= CNT_W'(RTCTI_RST_COUNT);
    end else if (wr_ival) begin
      interval_compare_reg_q <= sfr.wdata[CNT_W-1:0];
    end
  end

  // control register; hardware set of the flag beats a software clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_q <= rtcti_ctrl_s'(RTCTI_RST_CTRL);
    end else begin
      if (wr_ctrl) begin
        ctrl_q.unused <= 1'b0;
        ctrl_q.day_hour_mode <= wctrl.day_hour_mode;
        ctrl_q.timebase <= wctrl.timebase;
        ctrl_q.single_interval_mode <= wctrl.single_interval_mode;
        ctrl_q.time_clock_enable <= wctrl.time_clock_enable;
      end
      if (timeout && ctrl_q.single_interval_mode) begin
        ctrl_q.interval_counter_enable <= 1'b0;
      end else if (wr_ctrl) begin
        ctrl_q.interval_counter_enable <= wctrl.interval_counter_enable;
      end
      if (timeout) begin
        ctrl_q.interval_match_flag <= 1'b1;
      end else if (wr_ctrl) begin
        ctrl_q.interval_match_flag <= wctrl.interval_match_flag;
      end
    end
  end

  // interval counter held at zero while disabled, so enable starts from zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      time_interval_counter_q <= '0;
    end else if (!ctrl_q.interval_counter_enable || timeout) begin
      time_interval_counter_q <= '0;
    end else if (tb_tick) begin
      time_interval_counter_q <= ival_next;
    end
  end

  // registered read port, unmapped addresses read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr.rd) begin
      if (sfr.addr == RTCTI_ADDR_CTRL) begin
        sfr_rdata_q <= ctrl_q;
      end else if (sfr.addr == RTCTI_ADDR_SUBSEC) begin
        sfr_rdata_q <= subsecond_count_q;
      end else if (sfr.addr == RTCTI_ADDR_SEC) begin
        sfr_rdata_q <= rtc_s_count_q;
      end else if (sfr.addr == RTCTI_ADDR_MIN) begin
        sfr_rdata_q <= rtc_m_count_q;
      end else if (sfr.addr == RTCTI_ADDR_HOUR) begin
        sfr_rdata_q <= rtc_h_count_q;
      end else if (sfr.addr == RTCTI_ADDR_IVAL) begin
        sfr_rdata_q <= 8'(interval_compare_reg_q);
      end else begin
        sfr_rdata_q <= 8'h00;
      end
    end
  end

  assign sfr_rdata = sfr_rdata_q;
  assign interval_match_flag = ctrl_q.interval_match_flag;

  sequence s_ctrl_write(logic [7:0] v);
    wr_ctrl && (sfr.wdata == v) && !timeout;
  endsequence

  sequence s_sec_wrap;
    sec_tick && !wr_sec && !wr_min && (rtc_s_count_q == RTCTI_SEC_MAX);
  endsequence

  sequence s_min_wrap;
    min_tick && !wr_min && !wr_hour && (rtc_m_count_q == RTCTI_MIN_MAX);
  endsequence

  AST_SEC_WRAP: assert property (@(posedge clk) disable iff (reset)
    s_sec_wrap |=> (rtc_s_count_q == 8'h00)
    && (rtc_m_count_q == 8'(($past(rtc_m_count_q) == RTCTI_MIN_MAX) ? 8'h00
                            : $past(rtc_m_count_q) + 8'h01)))
    else $error("seconds did not wrap into minutes");

  AST_MIN_WRAP: assert property (@(posedge clk) disable iff (reset)
    s_min_wrap |=> (rtc_m_count_q == 8'h00) && (rtc_h_count_q != $past(rtc_h_count_q)))
    else $error("minutes did not wrap into hours");

  AST_HOUR24_WRAP: assert property (@(posedge clk) disable iff (reset)
    hour_tick && !wr_hour && ctrl_q.day_hour_mode && (rtc_h_count_q == 8'h17)
    |=> rtc_h_count_q == 8'h00)
    else $error("hours did not wrap after 23");

  AST_HOUR_FULL: assert property (@(posedge clk) disable iff (reset)
    hour_tick && !wr_hour && !ctrl_q.day_hour_mode && (rtc_h_count_q == 8'h17)
    |=> rtc_h_count_q == 8'h18)
    else $error("hours wrapped at 23 outside 24-hour mode");

  AST_HOLD_STOPPED: assert property (@(posedge clk) disable iff (reset)
    !ctrl_q.time_clock_enable && !wr_sub |=> $stable(subsecond_count_q))
    else $error("subsecond moved while clock enable clear");

  AST_SUB_WRAP: assert property (@(posedge clk) disable iff (reset)
    sub_tick && !wr_sub && !wr_sec && (subsecond_count_q == 8'h7f)
    |=> (subsecond_count_q == 8'h00) && (rtc_s_count_q != $past(rtc_s_count_q)))
    else $error("subsecond did not wrap into seconds");

  AST_CTRL_D0: assert property (@(posedge clk) disable iff (reset)
    s_ctrl_write(8'hd0) |=> ctrl_q.day_hour_mode && !ctrl_q.time_clock_enable
    && (ctrl_q.timebase == RTCTI_TB_SEC))
    else $error("0xd0 write gave wrong control state");

  AST_CTRL_D3: assert property (@(posedge clk) disable iff (reset)
    s_ctrl_write(8'hd3) ##0 !ctrl_q.interval_counter_enable |=> ctrl_q.time_clock_enable
    && ctrl_q.interval_counter_enable && (time_interval_counter_q == '0))
    else $error("0xd3 write did not start the interval counter");

  AST_MATCH_FLAG: assert property (@(posedge clk) disable iff (reset)
    timeout |=> interval_match_flag)
    else $error("match flag not set on interval match");

  AST_SINGLE: assert property (@(posedge clk) disable iff (reset)
    timeout && ctrl_q.single_interval_mode |=> !ctrl_q.interval_counter_enable
    && (time_interval_counter_q == '0))
    else $error("single interval did not stop");

  AST_RELOAD: assert property (@(posedge clk) disable iff (reset)
    timeout && !ctrl_q.single_interval_mode && !wr_ctrl |=> ctrl_q.interval_counter_enable
    && (time_interval_counter_q == '0))
    else $error("interval counter did not reload");

  AST_IVAL_STEP: assert property (@(posedge clk) disable iff (reset)
    ctrl_q.interval_counter_enable && tb_tick && !timeout
    |=> time_interval_counter_q == CNT_W'($past(time_interval_counter_q) + 1'b1))
    else $error("interval counter missed a tick");
endmodule : rtcti_top
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtcti_pkg::*;
  logic clk;
  logic reset;
  logic tick_128;
  rtcti_pkg::rtcti_sfr_s sfr;
  logic [7:0] sfr_rdata;
  logic interval_match_flag;
  int err_total;
  int compares;
  int cyc;

  rtcti_top #(.CNT_W(8)) i_dut (
    .clk(clk),
    .reset(reset),
    .tick_128(tick_128),
    .sfr(sfr),
    .sfr_rdata(sfr_rdata),
    .interval_match_flag(interval_match_flag)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  localparam int CYC_LIMIT = 30000;

  always @(posedge clk) begin
    cyc <= cyc + 1;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    sfr.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    sfr.rd <= 1'b0;
    #1;
    chk(what, exp, sfr_rdata);
  endtask : rd_chk

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      tick_128 <= 1'b1;
      @(posedge clk);
      tick_128 <= 1'b0;
    end
    #1;
  endtask : tick

  task automatic test_reset_values();
    rd_chk("seconds", RTCTI_ADDR_SEC, 8'h00);
    rd_chk("minutes", RTCTI_ADDR_MIN, 8'h00);
    rd_chk("hours", RTCTI_ADDR_HOUR, 8'h00);
    rd_chk("control", RTCTI_ADDR_CTRL, 8'h00);
    wr(8'ha7, 8'h55);
    rd_chk("unmapped", 8'ha7, 8'h00);
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_chain_wrap();
    wr(RTCTI_ADDR_CTRL, 8'hd0);
    wr(RTCTI_ADDR_SUBSEC, 8'h7f);
    wr(RTCTI_ADDR_SEC, 8'h3b);
    wr(RTCTI_ADDR_MIN, 8'h3b);
    wr(RTCTI_ADDR_HOUR, 8'h17);
    tick(3);
    rd_chk("frozen seconds", RTCTI_ADDR_SEC, 8'h3b);
    rd_chk("control d0", RTCTI_ADDR_CTRL, 8'h50);
    wr(RTCTI_ADDR_CTRL, 8'hd1);
    tick(1);
    rd_chk("subsec wrap", RTCTI_ADDR_SUBSEC, 8'h00);
    rd_chk("seconds wrap", RTCTI_ADDR_SEC, 8'h00);
    rd_chk("minutes wrap", RTCTI_ADDR_MIN, 8'h00);
    rd_chk("hours wrap", RTCTI_ADDR_HOUR, 8'h00);
    wr(RTCTI_ADDR_CTRL, 8'h00);
    wr(RTCTI_ADDR_SUBSEC, 8'h7f);
    wr(RTCTI_ADDR_SEC, 8'h3b);
    wr(RTCTI_ADDR_MIN, 8'h3b);
    wr(RTCTI_ADDR_HOUR, 8'h17);
    wr(RTCTI_ADDR_CTRL, 8'h01);
    tick(1);
    rd_chk("hours full range", RTCTI_ADDR_HOUR, 8'h18);
    $display("test chain_wrap done");
  endtask : test_chain_wrap

  task automatic test_interval_repeat();
    wr(RTCTI_ADDR_CTRL, 8'hd0);
    wr(RTCTI_ADDR_SUBSEC, 8'h00);
    wr(RTCTI_ADDR_SEC, 8'h00);
    wr(RTCTI_ADDR_IVAL, 8'h14);
    wr(RTCTI_ADDR_CTRL, 8'hd3);
    tick(20 * 128 - 1);
    chk("flag early", 8'h00, {7'h00, interval_match_flag});
    tick(1);
    chk("flag at 20 s", 8'h01, {7'h00, interval_match_flag});
    rd_chk("seconds 20", RTCTI_ADDR_SEC, 8'h14);
    wr(RTCTI_ADDR_CTRL, 8'hd3);
    chk("flag cleared", 8'h00, {7'h00, interval_match_flag});
    tick(20 * 128 - 1);
    chk("reload early", 8'h00, {7'h00, interval_match_flag});
    tick(1);
    chk("reload match", 8'h01, {7'h00, interval_match_flag});
    rd_chk("repeat control", RTCTI_ADDR_CTRL, 8'h57);
    $display("test interval_repeat done");
  endtask : test_interval_repeat

  task automatic test_single_shot();
    wr(RTCTI_ADDR_CTRL, 8'h40);
    wr(RTCTI_ADDR_IVAL, 8'h03);
    wr(RTCTI_ADDR_CTRL, 8'h4b);
    tick(2);
    chk("single early", 8'h00, {7'h00, interval_match_flag});
    tick(1);
    chk("single match", 8'h01, {7'h00, interval_match_flag});
    rd_chk("single control", RTCTI_ADDR_CTRL, 8'h4d);
    tick(3);
    rd_chk("single stays off", RTCTI_ADDR_CTRL, 8'h4d);
    $display("test single_shot done");
  endtask : test_single_shot

  task automatic test_coarse_timebase();
    wr(RTCTI_ADDR_CTRL, 8'h40);
    wr(RTCTI_ADDR_SUBSEC, 8'h7e);
    wr(RTCTI_ADDR_SEC, 8'h3b);
    wr(RTCTI_ADDR_MIN, 8'h3a);
    wr(RTCTI_ADDR_IVAL, 8'h01);
    wr(RTCTI_ADDR_CTRL, 8'h63);
    tick(1);
    chk("minute base early", 8'h00, {7'h00, interval_match_flag});
    tick(1);
    chk("minute base match", 8'h01, {7'h00, interval_match_flag});
    rd_chk("minutes step", RTCTI_ADDR_MIN, 8'h3b);
    wr(RTCTI_ADDR_CTRL, 8'h40);
    wr(RTCTI_ADDR_SUBSEC, 8'h7f);
    wr(RTCTI_ADDR_SEC, 8'h3b);
    wr(RTCTI_ADDR_MIN, 8'h3a);
    wr(RTCTI_ADDR_HOUR, 8'h05);
    wr(RTCTI_ADDR_CTRL, 8'h73);
    tick(1);
    chk("hour base early", 8'h00, {7'h00, interval_match_flag});
    wr(RTCTI_ADDR_SUBSEC, 8'h7f);
    wr(RTCTI_ADDR_SEC, 8'h3b);
    tick(1);
    chk("hour base match", 8'h01, {7'h00, interval_match_flag});
    rd_chk("hours step", RTCTI_ADDR_HOUR, 8'h06);
    $display("test coarse_timebase done");
  endtask : test_coarse_timebase

  task automatic test_mid_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("flag after reset", 8'h00, {7'h00, interval_match_flag});
    rd_chk("hours after reset", RTCTI_ADDR_HOUR, 8'h00);
    rd_chk("control after reset", RTCTI_ADDR_CTRL, 8'h00);
    $display("test mid_reset done");
  endtask : test_mid_reset

  initial begin
    err_total = 0;
    compares = 0;
    reset = 1'b1;
    tick_128 = 1'b0;
    sfr = '0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    fork
      begin
        test_reset_values();
        test_chain_wrap();
        test_interval_repeat();
        test_single_shot();
        test_coarse_timebase();
        test_mid_reset();
      end
      begin
        wait (cyc >= CYC_LIMIT);
        err_total++;
        $display("Error cycle limit expected %0d seen %0d", CYC_LIMIT, cyc);
      end
    join_any
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
